// File: hw/logic_block_pkg.sv
// Package for the logic block: sizes, select encodings and reset values.
// Assumes a single synthesis clock domain; configuration arrives as static ports.
package logic_block_pkg;
	localparam int NUM_SLICES   = 16;
	localparam int NUM_LOCAL    = 32;
	localparam int LOCAL_SEL_W  = 5;
	localparam int NUM_GLOBAL   = 8;
	localparam int LUT_INPUTS   = 4;
	localparam int LUT_ENTRIES  = 16;
	localparam int CTRL_SEL_W   = 2;
	localparam int GLOBAL_SEL_W = 3;
	localparam int PIN_SEL_W    = 3;
	localparam int NUM_PINS     = 8;

	// Control source encodings for clock enable and clear
	localparam logic [1:0] SRC_GLOBAL   = 2'h0;
	localparam logic [1:0] SRC_PIN      = 2'h1;
	localparam logic [1:0] SRC_INTERNAL = 2'h2;
	localparam logic [1:0] SRC_CONST    = 2'h3;

	localparam logic       REG_RESET    = 1'h0;
	localparam logic       DATA_FROM_LUT   = 1'h0;
	localparam logic       DATA_FROM_CHAIN = 1'h1;
endpackage

// File: hw/logic_slice.sv
// One slice: four-input table, carry, and a register with enable and clear.
// Assumes the parent supplies synchronised enable/clear levels and a fixed config.
`timescale 1ns/1ps
module logic_slice
	import logic_block_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Table inputs and configuration
	input  wire logic [LUT_INPUTS-1:0]  lut_in,
	input  wire logic [LUT_ENTRIES-1:0] truth_table,
	input  wire logic                   fb_sel,
	input  wire logic                   data_sel,
	// Register controls
	input  wire logic                   reg_en,
	input  wire logic                   reg_clr,
	input  wire logic                   chain_in,
	// Carry
	input  wire logic                   carry_in,
	output logic                        carry_out,
	// Outputs
	output logic                        lut_out,
	output logic                        reg_out
);
	logic [LUT_INPUTS-1:0] idx;
	logic                  reg_q;
	logic                  reg_d;

	always_comb begin
		idx = lut_in;
		if (fb_sel) begin
			idx[0] = reg_q;
		end
	end

	assign lut_out   = truth_table[idx];
	// Operands are table inputs 0 and 1
	assign carry_out = (lut_in[0] & lut_in[1]) | (carry_in & (lut_in[0] ^ lut_in[1]));

	always_comb begin
		reg_d = reg_q;
		if (reg_clr) begin
			reg_d = REG_RESET;
		end else if (reg_en) begin
			reg_d = (data_sel == DATA_FROM_CHAIN) ? chain_in : lut_out;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			reg_q <= REG_RESET;
		end else begin
			reg_q <= reg_d;
		end
	end

	assign reg_out = reg_q;

	clear_wins_a: assert property (@(posedge clk) disable iff (!nrst)
		reg_clr |=> (reg_q == REG_RESET)) else $error("Clear did not zero register");
	hold_no_en_a: assert property (@(posedge clk) disable iff (!nrst)
		(!reg_en && !reg_clr) |=> $stable(reg_q)) else $error("Register moved without enable");
	load_table_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_en && !reg_clr && data_sel == DATA_FROM_LUT) |=> (reg_q == $past(lut_out)))
		else $error("Register did not load table result");
endmodule // logic_slice

// File: hw/logic_block.sv
// Logic block of sixteen slices with local input selection and chain links.
// Assumes pins and fabric signals are asynchronous to clk; config is static.
// Clock source selection is not modelled; every slice runs on the one fabric clock.
`timescale 1ns/1ps
// Functional notes
// - Block holds sixteen identical slices sharing chain links.
// - Each slice input picks from at most thirty-two local signals.
// - Register chain feeds one slice's register into the next slice's register.
// - Table gives any function of four inputs from sixteen entries.
// - Register has data, clock, enable, clear; updates only when enabled or cleared.
// - Clock and clear come from global line, pin or internal logic; here all slices share clk, and global lines drive only clear.
// - Enable comes from pin or internal logic, never global line.
// - Combinational result bypasses the register to the output.
// - Table result and register output are separate simultaneous outputs.
// - Register output can feed back into the table inputs.
// - Dedicated carry in and out links between neighbouring slices.
// - Eight global lines reach every slice, usable only as the clear source.
module logic_block
	import logic_block_pkg::*;
#(
	parameter int SLICES = NUM_SLICES,
	parameter int GLOBALS = NUM_GLOBAL
) (
	// Clock and reset
	input  wire logic                                 clk,
	input  wire logic                                 nrst,
	// Asynchronous sources
	input  wire logic [GLOBALS-1:0]                   global_lines,
	input  wire logic [NUM_PINS-1:0]                  gp_pins,
	input  wire logic [NUM_LOCAL-1:0]                 local_in,
	// Per-slice configuration
	input  wire logic [SLICES*LUT_INPUTS*LOCAL_SEL_W-1:0] in_sel,
	input  wire logic [SLICES*LUT_ENTRIES-1:0]        truth_tables,
	input  wire logic [SLICES-1:0]                    fb_sel,
	input  wire logic [SLICES-1:0]                    data_sel,
	input  wire logic [SLICES*CTRL_SEL_W-1:0]         en_src,
	input  wire logic [SLICES*CTRL_SEL_W-1:0]         clr_src,
	input  wire logic [SLICES*GLOBAL_SEL_W-1:0]       glob_idx,
	input  wire logic [SLICES*PIN_SEL_W-1:0]          pin_idx,
	input  wire logic [SLICES-1:0]                    int_en,
	input  wire logic [SLICES-1:0]                    int_clr,
	// Chain boundary
	input  wire logic                                 carry_in,
	input  wire logic                                 chain_in,
	output logic                                      carry_out,
	output logic                                      chain_out,
	// Slice outputs
	output logic [SLICES-1:0]                         lut_out,
	output logic [SLICES-1:0]                         reg_out
);
	// Two-stage synchronisers; first stage read only by the second
	logic [GLOBALS-1:0]   glb_s1_q;
	logic [GLOBALS-1:0]   glb_s2_q;
	logic [GLOBALS-1:0]   glb_s1_d;
	logic [GLOBALS-1:0]   glb_s2_d;
	logic [NUM_PINS-1:0]  pin_s1_q;
	logic [NUM_PINS-1:0]  pin_s2_q;
	logic [NUM_PINS-1:0]  pin_s1_d;
	logic [NUM_PINS-1:0]  pin_s2_d;
	logic [NUM_LOCAL-1:0] loc_s1_q;
	logic [NUM_LOCAL-1:0] loc_s2_q;
	logic [NUM_LOCAL-1:0] loc_s1_d;
	logic [NUM_LOCAL-1:0] loc_s2_d;
	logic                 cin_s1_q;
	logic                 cin_s2_q;
	logic                 cin_s1_d;
	logic                 cin_s2_d;
	logic                 chn_s1_q;
	logic                 chn_s2_q;
	logic                 chn_s1_d;
	logic                 chn_s2_d;

	always_comb begin
		glb_s1_d = global_lines;
		glb_s2_d = glb_s1_q;
		pin_s1_d = gp_pins;
		pin_s2_d = pin_s1_q;
		loc_s1_d = local_in;
		loc_s2_d = loc_s1_q;
		cin_s1_d = carry_in;
		cin_s2_d = cin_s1_q;
		chn_s1_d = chain_in;
		chn_s2_d = chn_s1_q;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			glb_s1_q <= '0;
			glb_s2_q <= '0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			loc_s1_q <= '0;
			loc_s2_q <= '0;
			cin_s1_q <= 1'h0;
			cin_s2_q <= 1'h0;
			chn_s1_q <= 1'h0;
			chn_s2_q <= 1'h0;
		end else begin
			glb_s1_q <= glb_s1_d;
			glb_s2_q <= glb_s2_d;
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
			loc_s1_q <= loc_s1_d;
			loc_s2_q <= loc_s2_d;
			cin_s1_q <= cin_s1_d;
			cin_s2_q <= cin_s2_d;
			chn_s1_q <= chn_s1_d;
			chn_s2_q <= chn_s2_d;
		end
	end

	logic [SLICES:0]   carry_link;
	logic [SLICES:0]   chain_link;
	logic [SLICES-1:0] lut_w;
	logic [SLICES-1:0] reg_w;
	logic [SLICES-1:0] en_w;
	logic [SLICES-1:0] clr_w;

	assign carry_link[0] = cin_s2_q;
	assign chain_link[0] = chn_s2_q;

	genvar g;
	generate
		for (g = 0; g < SLICES; g++) begin : g_slice
			logic [LUT_INPUTS-1:0] sel_in;
			logic [CTRL_SEL_W-1:0] es;
			logic [CTRL_SEL_W-1:0] cs;
			logic [GLOBAL_SEL_W-1:0] gi;
			logic [PIN_SEL_W-1:0]  pi;

			always_comb begin
				for (int k = 0; k < LUT_INPUTS; k++) begin
					sel_in[k] = loc_s2_q[in_sel[(g*LUT_INPUTS+k)*LOCAL_SEL_W +: LOCAL_SEL_W]];
				end
			end

			assign es = en_src[g*CTRL_SEL_W +: CTRL_SEL_W];
			assign cs = clr_src[g*CTRL_SEL_W +: CTRL_SEL_W];
			assign gi = glob_idx[g*GLOBAL_SEL_W +: GLOBAL_SEL_W];
			assign pi = pin_idx[g*PIN_SEL_W +: PIN_SEL_W];

			always_comb begin
				case (es)
					SRC_PIN:      en_w[g] = pin_s2_q[pi];
					SRC_INTERNAL: en_w[g] = int_en[g];
					SRC_CONST:    en_w[g] = 1'h1;
					default:      en_w[g] = 1'h0; // Global line refused as enable
				endcase
				case (cs)
					SRC_GLOBAL:   clr_w[g] = glb_s2_q[gi];
					SRC_PIN:      clr_w[g] = pin_s2_q[pi];
					SRC_INTERNAL: clr_w[g] = int_clr[g];
					default:      clr_w[g] = 1'h0;
				endcase
			end

			logic_slice u_slice (
				.clk         (clk),
				.nrst        (nrst),
				.lut_in      (sel_in),
				.truth_table (truth_tables[g*LUT_ENTRIES +: LUT_ENTRIES]),
				.fb_sel      (fb_sel[g]),
				.data_sel    (data_sel[g]),
				.reg_en      (en_w[g]),
				.reg_clr     (clr_w[g]),
				.chain_in    (chain_link[g]),
				.carry_in    (carry_link[g]),
				.carry_out   (carry_link[g+1]),
				.lut_out     (lut_w[g]),
				.reg_out     (reg_w[g])
			);
			assign chain_link[g+1] = reg_w[g];
		end
	endgenerate

	// Outputs are registered, so table results appear one cycle late
	logic [SLICES-1:0] lut_q;
	logic [SLICES-1:0] reg_q;
	logic [SLICES-1:0] lut_d;
	logic [SLICES-1:0] reg_d;
	logic              cout_q;
	logic              cout_d;
	logic              chout_q;
	logic              chout_d;

	always_comb begin
		lut_d   = lut_w;
		reg_d   = reg_w;
		cout_d  = carry_link[SLICES];
		chout_d = chain_link[SLICES];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lut_q   <= '0;
			reg_q   <= '0;
			cout_q  <= 1'h0;
			chout_q <= 1'h0;
		end else begin
			lut_q   <= lut_d;
			reg_q   <= reg_d;
			cout_q  <= cout_d;
			chout_q <= chout_d;
		end
	end

	assign lut_out   = lut_q;
	assign reg_out   = reg_q;
	assign carry_out = cout_q;
	assign chain_out = chout_q;

	chain_shift_a: assert property (@(posedge clk) disable iff (!nrst)
		(en_w[1] && !clr_w[1] && data_sel[1] == DATA_FROM_CHAIN) |=> (g_slice[1].u_slice.reg_q == $past(reg_w[0])))
		else $error("Chain did not pass neighbour value");
	global_en_a: assert property (@(posedge clk) disable iff (!nrst)
		(en_src[CTRL_SEL_W-1:0] == SRC_GLOBAL) |-> !en_w[0]) else $error("Global line used as enable");
	carry_maj_a: assert property (@(posedge clk) disable iff (!nrst)
		carry_link[1] == ((g_slice[0].sel_in[0] + g_slice[0].sel_in[1] + 2'(carry_link[0])) >= 2'h2))
		else $error("Carry not majority");
	// The first edge after reset loads fresh slice values, so it is skipped
	out_copy_a: assert property (@(posedge clk) disable iff (!nrst)
		$past(nrst) |-> (lut_out == $past(lut_w) && reg_out == $past(reg_w)))
		else $error("Outputs do not follow slices");
endmodule // logic_block

// File: sim/fabric_model.sv
// Model of the routing fabric that feeds local signals into the block.
// Assumes the bench sets wanted levels; they land 1 ns after clk rises.
`timescale 1ns/1ps
module fabric_model (
	// Clock
	input  wire logic        clk,
	// Wanted levels and fabric lines
	input  wire logic [31:0] want,
	output logic      [31:0] local_in
);
	// Off-edge update keeps the synchronisers clear of races with the bench
	initial local_in = 32'h0000_0000;
	always @(posedge clk) local_in <= #1 want;
endmodule // fabric_model

// File: sim/tb_lut4_logic_slice_block.sv
// Self-checking bench for the logic block: table, register, chain, carry, feedback.
// Assumes a 125 MHz clock and two-cycle input synchronisers.
`timescale 1ns/1ps
module tb_lut4_logic_slice_block;
	import logic_block_pkg::*;
	logic         clk, nrst, carry_in, chain_in, carry_out, chain_out;
	logic [7:0]   global_lines, gp_pins;
	logic [31:0]  want, local_in;
	logic [319:0] in_sel;
	logic [255:0] truth_tables;
	logic [31:0]  en_src, clr_src;
	logic [15:0]  fb_sel, data_sel, int_en, int_clr, lut_out, reg_out;
	logic [47:0]  glob_idx, pin_idx;
	logic         r;
	int           errors, comparisons, i;
	fabric_model fab (.clk(clk), .want(want), .local_in(local_in));
	logic_block uut (.clk(clk), .nrst(nrst), .global_lines(global_lines), .gp_pins(gp_pins),
		.local_in(local_in), .in_sel(in_sel), .truth_tables(truth_tables), .fb_sel(fb_sel),
		.data_sel(data_sel), .en_src(en_src), .clr_src(clr_src), .glob_idx(glob_idx),
		.pin_idx(pin_idx), .int_en(int_en), .int_clr(int_clr), .carry_in(carry_in),
		.chain_in(chain_in), .carry_out(carry_out), .chain_out(chain_out), .lut_out(lut_out),
		.reg_out(reg_out));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("comparisons=%0d errors=%0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Four-input parity on slice 0, inputs at both ends of local routing
	task automatic lut_test();
		truth_tables[15:0] = 16'h6996;
		in_sel[19:0] = {5'h00, 5'h01, 5'h1e, 5'h1f};
		for (i = 0; i < 16; i++) begin
			want = {i[0], i[1], 28'h000_0000, i[2], i[3]};
			step(4);
			check(lut_out[0], ^i[3:0]);
			check(reg_out[0], 1'h0);
		end
	endtask
	// Enable, clear and their sources on slice 0
	task automatic reg_test();
		want = 32'h8000_0000;
		int_en[0] = 1'h1;
		step(5);
		check(reg_out[0], 1'h1);
		int_en[0] = 1'h0;
		want = 32'h0000_0000;
		step(5);
		check(reg_out[0], 1'h1);
		int_en[0] = 1'h1;
		want = 32'h8000_0000;
		int_clr[0] = 1'h1;
		clr_src[1:0] = SRC_INTERNAL;
		step(5);
		check(reg_out[0], 1'h0);
		int_clr[0] = 1'h0;
		en_src[1:0] = SRC_GLOBAL;
		global_lines = 8'hff;
		step(5);
		check(reg_out[0], 1'h0);
		// Pin 6 and line 5, so an index stuck at zero shows up
		en_src[1:0] = SRC_PIN;
		pin_idx[2:0] = 3'h6;
		gp_pins = 8'h40;
		step(5);
		check(reg_out[0], 1'h1);
		clr_src[1:0] = SRC_GLOBAL;
		glob_idx[2:0] = 3'h5;
		global_lines = 8'h20;
		step(5);
		check(reg_out[0], 1'h0);
		clr_src[1:0] = SRC_CONST;
		en_src[1:0] = SRC_CONST;
		step(5);
		check(reg_out[0], 1'h1);
		clr_src[1:0] = SRC_PIN;
		step(5);
		check(reg_out[0], 1'h0);
		clr_src[1:0] = SRC_CONST;
		en_src[1:0] = SRC_INTERNAL;
		global_lines = 8'h00;
		gp_pins = 8'h00;
	endtask
	// Register chain across all sixteen slices, then back to zero
	task automatic chain_test();
		data_sel = 16'hffff;
		int_en = 16'hffff;
		chain_in = 1'h1;
		step(24);
		check(reg_out, 16'hffff);
		check(chain_out, 1'h1);
		chain_in = 1'h0;
		step(24);
		check(reg_out, 16'h0000);
		check(chain_out, 1'h0);
		data_sel = 16'h0000;
		int_en = 16'h0000;
	endtask
	// Ripple carry: every slice adds local bits 0 and 1 and shows their sum bit
	task automatic carry_test();
		truth_tables = {16{16'h6666}};
		for (i = 0; i < 16; i++) begin
			in_sel[i*20 +: 20] = {10'h0, 5'h01, 5'h00};
		end
		for (i = 0; i < 8; i++) begin
			want = {30'h000_0000, i[1], i[0]};
			carry_in = i[2];
			step(6);
			check(carry_out, (i[0] & i[1]) | ((i[0] ^ i[1]) & i[2]));
			check(lut_out, (i[0] ^ i[1]) ? 16'hffff : 16'h0000);
		end
	endtask
	// Slice 2 feeds its register back as inverted table input 0, so it toggles
	task automatic fb_test();
		truth_tables[47:32] = 16'h5555;
		fb_sel[2] = 1'h1;
		int_en[2] = 1'h1;
		step(6);
		r = reg_out[2];
		step(1);
		check(reg_out[2], !r);
		step(1);
		check(reg_out[2], r);
	endtask
	// Mid-run reset while slice 2 toggles and the carry is high
	task automatic reset_test();
		nrst = 1'h0;
		step(2);
		check(reg_out, 16'h0000);
		check(lut_out, 16'h0000);
		check({carry_out, chain_out}, 2'h0);
		nrst = 1'h1;
		step(2);
	endtask
	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end
	initial begin
		// About ten times the expected run; a hang past it counts as a failure
		#20000;
		errors++;
		results();
	end
	initial begin
		errors = 0;
		comparisons = 0;
		nrst = 1'h0;
		carry_in = 1'h0;
		chain_in = 1'h0;
		global_lines = 8'h00;
		gp_pins = 8'h00;
		glob_idx = '0;
		pin_idx = '0;
		want = 32'h0000_0000;
		in_sel = '0;
		truth_tables = '0;
		en_src = {16{SRC_INTERNAL}};
		clr_src = {16{SRC_CONST}};
		fb_sel = 16'h0000;
		data_sel = 16'h0000;
		int_en = 16'h0000;
		int_clr = 16'h0000;
		step(16);
		nrst = 1'h1;
		lut_test();
		reg_test();
		chain_test();
		carry_test();
		fb_test();
		reset_test();
		results();
	end
endmodule // tb_lut4_logic_slice_block
